// ==== rtl/emp_pkg.sv ====
// Function
// [RL1] Command load: select 10, data, strobe pulse
// [RL2] Address low load: select 00, bytes 00
// [RL3] Command 0000 0100 reads fuse and lock
// [RL4] Byte selects pick fuse low/high/extended/lock
// [RL5] Command 0000 1000 reads signature bytes 0..2
// [RL6] Signature command, address 0, select high: calibration
// [RL7] Busy falls within 1 us of write
// [RL8] Write busy lasts 3.7 to 4.5 ms
// [RL9] Chip erase busy lasts 7.5 to 9 ms
// [RL10] Serial mode needs reset low, enable first
// [RL11] Serial link: clock, data in, data out
// [RL12] Data sampled on rising, shifted on falling
// [RL13] Serial clock phases longer than device cycles
// [RL14] Power-up: reset and clock low; pulse reset
// [RL15] Wait 20 ms before programming enable
// [RL16] Enable word is AC 53 then two bytes
// [RL17] Device echoes 53 during third byte
// [RL18] Send all four bytes; no echo, pulse reset
// [RL19] Page load low byte before high byte
// [RL20] Extended address byte kept until reloaded
// [RL21] Wait flash write delay before next access
// [RL22] Serial EEPROM byte write erases first
// [RL23] Chip erase sets all memory to FF
// [RL24] Reads return data, using stored extended address
// [RL25] Releasing reset ends the session
// [RL26] Bytes shift MSB first, aligned frames
package emp_pkg;

    localparam int CLK_PERIOD_NS   = 10;
    localparam int SCK_HALF_NS     = 250;
    localparam int SCK_HALF_CYC    = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PWRUP_WAIT_MS   = 20;
    localparam int PWRUP_WAIT_CYC  = PWRUP_WAIT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int FLASH_WAIT_US   = 4500;
    localparam int FLASH_WAIT_CYC  = FLASH_WAIT_US * 1000 / CLK_PERIOD_NS;
    localparam int EEPROM_WAIT_US  = 9000;
    localparam int EEPROM_WAIT_CYC = EEPROM_WAIT_US * 1000 / CLK_PERIOD_NS;
    localparam int ERASE_WAIT_US   = 9000;
    localparam int ERASE_WAIT_CYC  = ERASE_WAIT_US * 1000 / CLK_PERIOD_NS;
    localparam int RST_PULSE_NS    = 1000;
    localparam int RST_PULSE_CYC   = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PAR_SETUP_NS    = 67;
    localparam int PAR_SETUP_CYC   = (PAR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PAR_HIGH_NS     = 150;
    localparam int PAR_HIGH_CYC    = (PAR_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PAR_HOLD_NS     = 67;
    localparam int PAR_HOLD_CYC    = (PAR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PAR_STEP_CYC    = PAR_SETUP_CYC + PAR_HIGH_CYC + PAR_HOLD_CYC;
    localparam int PAR_OE_DV_NS    = 250;
    localparam int PAR_READ_CYC    = (PAR_OE_DV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 4;

    localparam logic [7:0]  SER_PEN_B1      = 8'h00ac;
    localparam logic [7:0]  SER_PEN_B2      = 8'h0053;
    localparam logic [31:0] SER_PEN_WORD    = 32'hac53_0000;
    localparam logic [2:0]  SER_ERASE_TOP   = 3'h4;
    localparam logic [7:0]  INS_LOAD_LO     = 8'h0040;
    localparam logic [7:0]  INS_LOAD_HI     = 8'h0048;
    localparam logic [7:0]  INS_WR_PAGE     = 8'h004c;
    localparam logic [7:0]  INS_WR_EE       = 8'h00c0;
    localparam logic [7:0]  INS_WR_EE_PAGE  = 8'h00c2;
    localparam logic [7:0]  PAR_CMD_FUSE_RD = 8'h0004;
    localparam logic [7:0]  PAR_CMD_SIG_RD  = 8'h0008;
    localparam logic [1:0]  XA_CMD          = 2'h2;
    localparam logic [1:0]  XA_ADDR         = 2'h0;
    localparam logic [1:0]  BS_ADDR_LO      = 2'h0;

    typedef enum logic [3:0] {
        ST_OFF      = 4'h0,
        ST_PWRUP    = 4'h1,
        ST_PEN      = 4'h2,
        ST_RSTPULSE = 4'h3,
        ST_READY    = 4'h4,
        ST_XFER     = 4'h5,
        ST_WRWAIT   = 4'h6,
        ST_PAR      = 4'h7
    } emp_state_e;

    typedef struct packed {
        logic dev_reset_n;
        logic serial_clock;
        logic serial_prog_data_in;
    } emp_ser_pins_s;

    typedef struct packed {
        logic [1:0] load_action_select;
        logic       byte_select_hi;
        logic       byte_select_lo;
        logic       crystal_strobe_input;
        logic       read_enable_n;
        logic [7:0] data;
        logic       data_oe_n;
    } emp_par_pins_s;

    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] addr_lo;
        logic [1:0] read_bs;
    } emp_par_req_s;

endpackage

// ==== rtl/emp_ser_shift.sv ====
`timescale 1ns/1ps
module emp_ser_shift (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic        start_i,
    input  wire logic [31:0] tx_word_i,
    input  wire logic        pdo_i,
    output logic             sck_o,
    output logic             pdi_o,
    output logic             busy_o,
    output logic             done_o,
    output logic [31:0]      rx_word_o
);
    logic [15:0] half_r;
    logic [4:0]  bit_r;
    logic        busy_r;
    logic        sck_r;
    logic        pdi_r;
    logic        done_r;
    logic [31:0] tx_r;
    logic [31:0] rx_r;

    wire half_end = half_r == 16'(emp_pkg::SCK_HALF_CYC - 1);
    wire last_bit = bit_r == 5'h1f;
    wire tx_msb   = tx_word_i[31];

    // Each phase lasts the full half period so slow device clocks still see both levels.
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            half_r <= 16'h0000;
            bit_r  <= 5'h00;
            busy_r <= 1'b0;
            sck_r  <= 1'b0;
            pdi_r  <= 1'b0;
            done_r <= 1'b0;
            tx_r   <= 32'h0000_0000;
            rx_r   <= 32'h0000_0000;
        end else begin
            done_r <= 1'b0;
            if (start_i && !busy_r) begin
                busy_r <= 1'b1;
                tx_r   <= tx_word_i;
                pdi_r  <= tx_word_i[31]; // RL26
                sck_r  <= 1'b0;
                half_r <= 16'h0000;
                bit_r  <= 5'h00;
            end else if (busy_r) begin
                if (!half_end) begin
                    half_r <= half_r + 16'h0001; // RL13
                end else begin
                    half_r <= 16'h0000;
                    if (!sck_r) begin
                        sck_r <= 1'b1;
                        rx_r  <= {rx_r[30:0], pdo_i}; // RL12
                    end else begin
                        sck_r <= 1'b0;
                        if (last_bit) begin
                            busy_r <= 1'b0;
                            done_r <= 1'b1;
                        end else begin
                            bit_r <= bit_r + 5'h01;
                            tx_r  <= {tx_r[30:0], 1'b0};
                            pdi_r <= tx_r[30]; // RL12
                        end
                    end
                end
            end
        end
    end

    assign sck_o     = sck_r;
    assign pdi_o     = pdi_r;
    assign busy_o    = busy_r;
    assign done_o    = done_r;
    assign rx_word_o = rx_r;

    sck_high_len_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL13
        $rose(sck_r) |-> sck_r [*8]) else $error("serial clock high phase too short");
    sck_low_len_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL13
        $fell(sck_r) && busy_r |-> !sck_r [*8]) else $error("serial clock low phase too short");
    msb_first_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL26
        start_i && !busy_r |=> pdi_r == $past(tx_msb)) else $error("first bit is not the MSB");
    pdi_stable_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL12
        $rose(sck_r) |-> $stable(pdi_r)) else $error("data changed at the rising clock edge");
endmodule

// ==== rtl/emp_host_ctrl.sv ====
`timescale 1ns/1ps
module emp_host_ctrl #(
    parameter int PWRUP_WAIT_CYC  = emp_pkg::PWRUP_WAIT_CYC,
    parameter int FLASH_WAIT_CYC  = emp_pkg::FLASH_WAIT_CYC,
    parameter int EEPROM_WAIT_CYC = emp_pkg::EEPROM_WAIT_CYC,
    parameter int ERASE_WAIT_CYC  = emp_pkg::ERASE_WAIT_CYC
) (
    input  wire logic                  clk_sys_i,
    input  wire logic                  rst_i,
    input  wire logic                  session_start_i,
    input  wire logic                  session_end_i,
    input  wire logic                  cmd_valid_i,
    output logic                       cmd_ready_o,
    input  wire logic [31:0]           cmd_word_i,
    output logic                       cmd_err_o,
    output logic                       rsp_valid_o,
    output logic [31:0]                rsp_word_o,
    output logic                       prog_enabled_o,
    output logic                       sync_retry_o,
    input  wire logic                  par_req_valid_i,
    output logic                       par_req_ready_o,
    input  wire emp_pkg::emp_par_req_s par_req_i,
    output logic                       par_rsp_valid_o,
    output logic [7:0]                 par_rsp_data_o,
    output emp_pkg::emp_ser_pins_s     ser_pins_o,
    input  wire logic                  serial_prog_data_out_i,
    output emp_pkg::emp_par_pins_s     par_pins_o,
    input  wire logic [7:0]            par_data_i
);
    emp_pkg::emp_state_e    state_r;
    emp_pkg::emp_state_e    state_nxt;
    logic [1:0]             pdo_sync_r;
    logic [7:0]             pd_s1_r;
    logic [7:0]             pd_s2_r;
    logic [31:0]            wait_r;
    logic [31:0]            wait_nxt;
    logic [31:0]            pend_wait_r;
    logic                   dev_rst_n_r;
    logic                   sync_retry_r;
    logic                   rsp_valid_r;
    logic [31:0]            rsp_word_r;
    logic                   cmd_err_r;
    logic                   lo_ok_r;
    logic [6:0]             lo_addr_r;
    emp_pkg::emp_par_req_s  par_req_r;
    logic [1:0]             step_r;
    logic [5:0]             pcnt_r;
    emp_pkg::emp_par_pins_s par_pins_r;
    logic                   par_rsp_valid_r;
    logic [7:0]             par_rsp_data_r;
    logic                   shift_sck;
    logic                   shift_pdi;
    logic                   shift_done;
    logic [31:0]            shift_rx;

    // Decode of the user's instruction word, byte 1 in the top bits.
    wire [7:0] b1        = cmd_word_i[31:24];
    wire [7:0] b2        = cmd_word_i[23:16];
    wire       wait_done = wait_r == 32'h0000_0000;
    wire       is_lo_ld  = b1 == emp_pkg::INS_LOAD_LO;
    wire       is_hi_ld  = b1 == emp_pkg::INS_LOAD_HI;
    wire       hi_bad    = is_hi_ld && !(lo_ok_r && lo_addr_r == cmd_word_i[14:8]);
    wire       is_erase  = b1 == emp_pkg::SER_PEN_B1 && b2[7:5] == emp_pkg::SER_ERASE_TOP;
    wire       is_fuse   = b1 == emp_pkg::SER_PEN_B1 && b2 != emp_pkg::SER_PEN_B2 && !is_erase;
    wire       is_ee_wr  = b1 == emp_pkg::INS_WR_EE || b1 == emp_pkg::INS_WR_EE_PAGE;
    wire       is_fl_wr  = b1 == emp_pkg::INS_WR_PAGE || is_fuse;
    wire [31:0] cmd_wait = is_erase ? 32'(ERASE_WAIT_CYC) :
                           is_ee_wr ? 32'(EEPROM_WAIT_CYC) :
                           is_fl_wr ? 32'(FLASH_WAIT_CYC) : 32'h0000_0000;
    wire       cmd_fire  = cmd_valid_i && cmd_ready_o;
    wire       cmd_send  = cmd_fire && !hi_bad; // RL19
    wire       pen_start = (state_r == emp_pkg::ST_PWRUP || state_r == emp_pkg::ST_RSTPULSE) && wait_done;
    wire       shift_go  = pen_start || cmd_send;
    wire [31:0] shift_tx = pen_start ? emp_pkg::SER_PEN_WORD : cmd_word_i; // RL16
    wire       echo_ok   = shift_rx[15:8] == emp_pkg::SER_PEN_B2; // RL17
    wire       par_fire  = par_req_valid_i && par_req_ready_o;

    // Parallel reads run three steps: command load, address low load, read with the bus released.
    wire       par_on    = state_r == emp_pkg::ST_PAR;
    wire       rd_step   = step_r == 2'h2;
    wire [5:0] step_last = rd_step ? 6'(emp_pkg::PAR_READ_CYC - 1) : 6'(emp_pkg::PAR_STEP_CYC - 1);
    wire       step_end  = pcnt_r == step_last;
    wire       par_done  = par_on && rd_step && step_end;
    wire       strobe_w  = par_on && !rd_step && pcnt_r >= 6'(emp_pkg::PAR_SETUP_CYC)
                           && pcnt_r < 6'(emp_pkg::PAR_SETUP_CYC + emp_pkg::PAR_HIGH_CYC); // RL1
    wire [1:0] xa_w      = step_r == 2'h0 ? emp_pkg::XA_CMD : emp_pkg::XA_ADDR; // RL1 RL2
    wire [1:0] bs_w      = rd_step ? par_req_r.read_bs : emp_pkg::BS_ADDR_LO; // RL2 RL4
    wire [7:0] pdata_w   = step_r == 2'h0 ? par_req_r.cmd : par_req_r.addr_lo; // RL3
    wire       in_sess   = state_nxt != emp_pkg::ST_OFF && state_nxt != emp_pkg::ST_PAR
                           && state_nxt != emp_pkg::ST_RSTPULSE;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            emp_pkg::ST_OFF: begin
                if (session_start_i) begin
                    state_nxt = emp_pkg::ST_PWRUP;
                end else if (par_fire) begin
                    state_nxt = emp_pkg::ST_PAR;
                end
            end
            emp_pkg::ST_PWRUP: begin
                if (wait_done) begin
                    state_nxt = emp_pkg::ST_PEN; // RL15
                end
            end
            emp_pkg::ST_PEN: begin
                if (shift_done) begin
                    state_nxt = echo_ok ? emp_pkg::ST_READY : emp_pkg::ST_RSTPULSE; // RL18
                end
            end
            emp_pkg::ST_RSTPULSE: begin
                if (wait_done) begin
                    state_nxt = emp_pkg::ST_PEN;
                end
            end
            emp_pkg::ST_READY: begin
                if (session_end_i) begin
                    state_nxt = emp_pkg::ST_OFF; // RL25
                end else if (cmd_send) begin
                    state_nxt = emp_pkg::ST_XFER;
                end
            end
            emp_pkg::ST_XFER: begin
                if (shift_done) begin
                    state_nxt = pend_wait_r != 32'h0000_0000 ? emp_pkg::ST_WRWAIT : emp_pkg::ST_READY;
                end
            end
            emp_pkg::ST_WRWAIT: begin
                if (wait_done) begin
                    state_nxt = emp_pkg::ST_READY; // RL21
                end
            end
            emp_pkg::ST_PAR: begin
                if (par_done) begin
                    state_nxt = emp_pkg::ST_OFF;
                end
            end
            default: begin
                state_nxt = emp_pkg::ST_OFF;
            end
        endcase
    end

    // The delay counter reloads on each state change, so every wait starts from a fresh count.
    always_comb begin
        wait_nxt = wait_done ? 32'h0000_0000 : wait_r - 32'h0000_0001;
        if (state_nxt != state_r) begin
            case (state_nxt)
                emp_pkg::ST_PWRUP:    wait_nxt = 32'(PWRUP_WAIT_CYC); // RL14 RL15
                emp_pkg::ST_RSTPULSE: wait_nxt = 32'(emp_pkg::RST_PULSE_CYC); // RL18
                emp_pkg::ST_WRWAIT:   wait_nxt = pend_wait_r; // RL21
                default:              wait_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        pdo_sync_r <= {pdo_sync_r[0], serial_prog_data_out_i};
        pd_s1_r    <= par_data_i;
        pd_s2_r    <= pd_s1_r;
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_r      <= emp_pkg::ST_OFF;
            wait_r       <= 32'h0000_0000;
            dev_rst_n_r  <= 1'b1;
            sync_retry_r <= 1'b0;
            rsp_valid_r  <= 1'b0;
            cmd_err_r    <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            wait_r       <= wait_nxt;
            dev_rst_n_r  <= !in_sess; // RL10 RL14 RL25
            sync_retry_r <= state_r == emp_pkg::ST_PEN && shift_done && !echo_ok; // RL18
            rsp_valid_r  <= state_r == emp_pkg::ST_XFER && shift_done; // RL24
            cmd_err_r    <= cmd_fire && hi_bad; // RL19
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pend_wait_r <= 32'h0000_0000;
            rsp_word_r  <= 32'h0000_0000;
            lo_ok_r     <= 1'b0;
            lo_addr_r   <= 7'h00;
        end else begin
            if (cmd_send) begin
                pend_wait_r <= cmd_wait;
            end
            if (state_r == emp_pkg::ST_XFER && shift_done) begin
                rsp_word_r <= shift_rx;
            end
            if (state_nxt == emp_pkg::ST_OFF) begin
                lo_ok_r <= 1'b0;
            end else if (cmd_send && is_lo_ld) begin
                lo_ok_r   <= 1'b1; // RL19
                lo_addr_r <= cmd_word_i[14:8];
            end else if (cmd_send && is_hi_ld) begin
                lo_ok_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            par_req_r       <= '0;
            step_r          <= 2'h0;
            pcnt_r          <= 6'h00;
            par_pins_r      <= '{2'h0, 1'b0, 1'b0, 1'b0, 1'b1, 8'h00, 1'b1};
            par_rsp_valid_r <= 1'b0;
            par_rsp_data_r  <= 8'h00;
        end else begin
            if (par_fire) begin
                par_req_r <= par_req_i;
                step_r    <= 2'h0;
                pcnt_r    <= 6'h00;
            end else if (par_on) begin
                pcnt_r <= step_end ? 6'h00 : pcnt_r + 6'h01;
                step_r <= step_end ? step_r + 2'h1 : step_r;
            end
            par_pins_r      <= '{xa_w, bs_w[1], bs_w[0], strobe_w, !(par_on && rd_step), pdata_w,
                                 !(par_on && !rd_step)};
            par_rsp_valid_r <= par_done;
            if (par_done) begin
                par_rsp_data_r <= pd_s2_r; // RL4
            end
        end
    end

    emp_ser_shift u_shift (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .start_i   (shift_go),
        .tx_word_i (shift_tx),
        .pdo_i     (pdo_sync_r[1]),
        .sck_o     (shift_sck),
        .pdi_o     (shift_pdi),
        .busy_o    (),
        .done_o    (shift_done),
        .rx_word_o (shift_rx)
    );

    assign cmd_ready_o     = state_r == emp_pkg::ST_READY && !session_end_i;
    assign cmd_err_o       = cmd_err_r;
    assign rsp_valid_o     = rsp_valid_r;
    assign rsp_word_o      = rsp_word_r;
    assign prog_enabled_o  = state_r == emp_pkg::ST_READY || state_r == emp_pkg::ST_XFER
                             || state_r == emp_pkg::ST_WRWAIT;
    assign sync_retry_o    = sync_retry_r;
    assign par_req_ready_o = state_r == emp_pkg::ST_OFF && !session_start_i;
    assign par_rsp_valid_o = par_rsp_valid_r;
    assign par_rsp_data_o  = par_rsp_data_r;
    assign ser_pins_o      = '{dev_rst_n_r, shift_sck, shift_pdi}; // RL11
    assign par_pins_o      = par_pins_r;

    pwrup_pins_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL14
        state_r == emp_pkg::ST_PWRUP |-> !dev_rst_n_r && !shift_sck) else $error("reset or clock high in power-up");
    session_reset_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL10
        prog_enabled_o |-> !dev_rst_n_r) else $error("session active with reset released");
    enable_first_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL10
        shift_go && shift_tx != emp_pkg::SER_PEN_WORD |-> state_r == emp_pkg::ST_READY)
        else $error("instruction sent before programming enable");
    echo_retry_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL18
        state_r == emp_pkg::ST_PEN && shift_done && !echo_ok |=> dev_rst_n_r && sync_retry_r)
        else $error("missing echo did not pulse reset");
    rst_pulse_len_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL14
        state_r == emp_pkg::ST_RSTPULSE && !wait_done |=> state_r == emp_pkg::ST_RSTPULSE && dev_rst_n_r)
        else $error("reset pulse ended early");
    write_wait_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL21
        state_r == emp_pkg::ST_WRWAIT && !wait_done |=> !cmd_ready_o) else $error("access during write delay");
    end_release_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL25
        state_r == emp_pkg::ST_READY && session_end_i |=> ##1 dev_rst_n_r) else $error("reset not released at end");
    strobe_width_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL1
        $rose(par_pins_r.crystal_strobe_input) |-> par_pins_r.crystal_strobe_input [*8])
        else $error("strobe pulse too short");
    cmd_select_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL1
        par_pins_r.crystal_strobe_input && par_pins_r.load_action_select == emp_pkg::XA_CMD
        |-> !par_pins_r.data_oe_n && !par_pins_r.byte_select_lo) else $error("command load badly set up");
    pwrup_wait_a: assert property (@(posedge clk_sys_i) disable iff (rst_i) // RL15
        state_r == emp_pkg::ST_OFF && session_start_i |=> state_r == emp_pkg::ST_PWRUP [*8])
        else $error("enable sent without power-up wait");

    pen_ok_c: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        state_r == emp_pkg::ST_PEN ##1 state_r == emp_pkg::ST_READY);
    retry_c: cover property (@(posedge clk_sys_i) disable iff (rst_i) sync_retry_r);
    wrwait_c: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        state_r == emp_pkg::ST_WRWAIT ##1 state_r == emp_pkg::ST_READY);
    par_read_c: cover property (@(posedge clk_sys_i) disable iff (rst_i) par_rsp_valid_r);
endmodule

// ==== sim/emp_dev_model.sv ====
`timescale 1ns/1ps
module emp_dev_model (
    input  wire emp_pkg::emp_ser_pins_s ser_i,
    input  wire emp_pkg::emp_par_pins_s par_i,
    input  wire logic                   mute_i,
    output logic                        pdo_o,
    output logic [7:0]                  bus_o
);
    // Fuse, lock, signature and calibration contents; the values are arbitrary.
    logic [7:0] tbl [0:7] = '{8'h00e1, 8'h0011, 8'h0022, 8'h0033, 8'h00c5, 8'h0044, 8'h0055, 8'h0066};
    logic [7:0] cmd_r = 8'h0000;
    logic [7:0] adr_r = 8'h0000;
    logic [7:0] last_r = 8'h0000;
    logic [7:0] rx_r = 8'h0000;
    logic [7:0] tx_r = 8'h0000;
    logic [2:0] cnt_r = 3'h0;
    wire  [2:0] sel = (cmd_r == 8'h0008) ? (par_i.byte_select_lo ? 3'h7 : {1'b1, adr_r[1:0]})
                    : {1'b0, par_i.byte_select_hi, par_i.byte_select_lo};
    wire        drive = !par_i.read_enable_n && par_i.data_oe_n && (cmd_r == 8'h0004 || cmd_r == 8'h0008);
    always @(posedge par_i.crystal_strobe_input) begin
        if (par_i.load_action_select == 2'h2) cmd_r <= par_i.data;
        else if (par_i.load_action_select == 2'h0 && !par_i.byte_select_hi && !par_i.byte_select_lo) adr_r <= par_i.data;
    end
    // A released bus shows the inverse of its last value so a stale sample cannot pass.
    always @* if (drive) last_r = tbl[sel];
    assign bus_o = drive ? tbl[sel] : ~last_r;
    always @(posedge ser_i.serial_clock) if (!ser_i.dev_reset_n) begin
        rx_r  <= {rx_r[6:0], ser_i.serial_prog_data_in};
        cnt_r <= cnt_r + 3'h1;
    end
    always @(posedge ser_i.dev_reset_n) cnt_r <= 3'h0;
    // Each byte returns the byte received just before it, which yields the enable echo.
    always @(negedge ser_i.serial_clock) tx_r <= (cnt_r == 3'h0) ? rx_r : {tx_r[6:0], 1'b0};
    assign pdo_o = ser_i.dev_reset_n ? ~tx_r[7] : tx_r[7] ^ mute_i;
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin n_mismatch++; \
    $display("unexpected %s expected %h seen %h", nm, e, s); end end
module testbench;
    logic clk_sys_i = 0, rst_i = 1, ss = 0, se = 0, cv = 0, pv = 0, mute = 0;
    logic [31:0] cw = 32'h0000_0000;
    emp_pkg::emp_par_req_s  preq = '0;
    emp_pkg::emp_ser_pins_s sp;
    emp_pkg::emp_par_pins_s pp;
    logic        serial_prog_data_out, cr, cerr, rv, pen, sr, prr, prv;
    logic [31:0] rw;
    logic [7:0]  pd, dbus;
    wire  [7:0]  pbus = pp.data_oe_n ? dbus : pp.data;
    int          n_mismatch = 0, n_checks = 0;
    logic [7:0]  ref_v [0:7] = '{8'h00e1, 8'h0011, 8'h0022, 8'h0033, 8'h00c5, 8'h0044, 8'h0055, 8'h0066};
    emp_host_ctrl #(.PWRUP_WAIT_CYC(200), .FLASH_WAIT_CYC(200), .EEPROM_WAIT_CYC(200), .ERASE_WAIT_CYC(200)) dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .session_start_i(ss), .session_end_i(se), .cmd_valid_i(cv),
        .cmd_ready_o(cr), .cmd_word_i(cw), .cmd_err_o(cerr), .rsp_valid_o(rv), .rsp_word_o(rw),
        .prog_enabled_o(pen), .sync_retry_o(sr), .par_req_valid_i(pv), .par_req_ready_o(prr), .par_req_i(preq),
        .par_rsp_valid_o(prv), .par_rsp_data_o(pd), .ser_pins_o(sp), .serial_prog_data_out_i(serial_prog_data_out),
        .par_pins_o(pp), .par_data_i(pbus));
    emp_dev_model model (.ser_i(sp), .par_i(pp), .mute_i(mute), .pdo_o(serial_prog_data_out), .bus_o(dbus));
    initial forever #5 clk_sys_i = ~clk_sys_i;
    task automatic wait_for(ref logic s, input int lim);
        for (int k = 0; k < lim && s !== 1'b1; k++) begin
            @(posedge clk_sys_i);
            #1;
        end
        if (s !== 1'b1) n_mismatch++;
    endtask
    task automatic par_read(input logic [7:0] c, input logic [7:0] a, input logic [1:0] bs, input logic [7:0] e);
        wait_for(prr, 50);
        @(posedge clk_sys_i);
        pv <= 1'b1;
        preq <= '{cmd: c, addr_lo: a, read_bs: bs};
        @(posedge clk_sys_i);
        pv <= 1'b0;
        #1;
        `CHK("par busy", 1'b0, prr)
        wait_for(prv, 200);
        `CHK("par valid", 1'b1, prv)
        `CHK("par data", e, pd)
    endtask
    task automatic fuse_reads();
        for (int b = 0; b < 4; b++) par_read(8'h0004, 8'h0000, b[1:0], ref_v[b]);
    endtask
    task automatic sig_reads();
        for (int a = 0; a < 3; a++) par_read(8'h0008, a[7:0], 2'h0, ref_v[4 + a]);
        par_read(8'h0008, 8'h0000, 2'h1, ref_v[7]);
    endtask
    task automatic ser_cmd(input logic [31:0] w);
        wait_for(cr, 3000);
        @(posedge clk_sys_i);
        cv <= 1'b1;
        cw <= w;
        @(posedge clk_sys_i);
        cv <= 1'b0;
        wait_for(rv, 3000);
        `CHK("rsp valid", 1'b1, rv)
        `CHK("rsp word", w[31:8], rw[23:0])
    endtask
    // A high-byte load with no matching low load is taken but never shifted out.
    task automatic ser_refused(input logic [31:0] w);
        wait_for(cr, 3000);
        @(posedge clk_sys_i);
        cv <= 1'b1;
        cw <= w;
        @(posedge clk_sys_i);
        cv <= 1'b0;
        #1;
        `CHK("refused err", 1'b1, cerr)
        `CHK("refused ready", 1'b1, cr)
    endtask
    task automatic serial_session();
        @(posedge clk_sys_i);
        mute <= 1'b1;
        ss <= 1'b1;
        @(posedge clk_sys_i);
        ss <= 1'b0;
        #1;
        `CHK("reset pin", 1'b0, sp.dev_reset_n)
        wait_for(sr, 4000);
        `CHK("retry", 1'b1, sr)
        @(posedge clk_sys_i);
        mute <= 1'b0;
        wait_for(pen, 4000);
        `CHK("enabled", 1'b1, pen)
        `CHK("clock idle", 1'b0, sp.serial_clock)
        ser_cmd(32'h30a1_5c00);
        ser_cmd(32'h5800_0800);
        ser_refused(32'h4800_0500);
        ser_cmd(32'h4000_0500);
        ser_cmd(32'h4800_05a5);
        ser_cmd(32'h4c00_0000);
        `CHK("write wait", 1'b0, cr)
        wait_for(cr, 3000);
        @(posedge clk_sys_i);
        se <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        se <= 1'b0;
        #1;
        `CHK("reset released", 1'b1, sp.dev_reset_n)
        `CHK("enabled off", 1'b0, pen)
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #500000;
        n_mismatch++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        fuse_reads();
        sig_reads();
        serial_session();
        wrap_up();
    end
endmodule
